// ===== bench/dac_channel_trigger_wave_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "dac_ctrl_consts.svh"
`define CK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module dac_channel_trigger_wave_control_bench;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [3:0] trig = 4'h0;
    logic [31:0] rdata;
    logic [11:0] out;
    logic conv_en;
    logic [11:0] h;
    logic [11:0] v;
    logic [3:0] n;
    logic [11:0] lf;
    int num_errors = 0;
    int checks_done = 0;
    dac_channel_trigger_wave_control dut_u (.sys_clk(sys_clk), .srst(srst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .tim6_trigger_out(trig[0]), .tim7_trigger_out(trig[1]), .tim2_trigger_out(trig[2]),
        .ext_line9(trig[3]), .output_data_reg(out), .converter_enable(conv_en));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    function automatic int amp_of(input logic [3:0] s);
        amp_of = (s >= 4'hb) ? 4095 : (2 << s) - 1;
    endfunction
    function automatic logic [11:0] lfsr_next(input logic [11:0] s);
        lfsr_next = {s[10:0], ^(s & `LFSR_TAPS)};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        `CK("rdata", e, rdata)
    endtask
    task automatic ctrl(input logic ten, input logic [2:0] ts, input logic [1:0] wv,
        input logic [3:0] ma);
        wr(`OFF_CTRL, {20'h0, ma, wv, ts, ten, 2'b01});
    endtask
    task automatic rst();
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        void'($urandom(63430));
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        #1;
        `CK("out", 12'h000, out)
        wr(`OFF_CTRL, 32'h0);
        @(posedge sys_clk);
        #1;
        `CK("conv_en", 1'b0, conv_en)
        n = 4'($urandom);
        ctrl(1'b0, 3'h7, 2'b01, n);
        @(posedge sys_clk);
        #1;
        `CK("conv_en", 1'b1, conv_en)
        rd(`OFF_CTRL, {20'h0, n, 8'h79});
        rd(8'h14, 32'h0);
        rd(`OFF_SWTRIG, 32'h0);
        repeat (4) begin
            h = 12'($urandom);
            wr(`OFF_HOLD, {20'h0, h});
            @(posedge sys_clk);
            #1;
            `CK("out", h, out)
            rd(`OFF_OUT, {20'h0, h});
        end
        rd(`OFF_HOLD, {20'h0, h});
        rd(`OFF_STATUS, 32'h1);
        v = h;
        ctrl(1'b1, 3'h0, 2'b00, 4'h0);
        wr(`OFF_HOLD, {20'h0, ~v});
        wr(`OFF_SWTRIG, 32'h1);
        #1;
        `CK("out", v, out)
        ctrl(1'b1, 3'h7, 2'b00, 4'h0);
        wr(`OFF_SWTRIG, 32'h1);
        #1;
        `CK("out", ~v, out)
        for (int i = 0; i < 4; i++) begin
            ctrl(1'b1, 3'(2 * i), 2'b00, 4'h0);
            h = 12'($urandom);
            wr(`OFF_HOLD, {20'h0, h});
            @(posedge sys_clk);
            trig[i] <= 1'b1;
            repeat (12) @(posedge sys_clk);
            #1;
            `CK("hw", h, out)
            wr(`OFF_HOLD, {20'h0, ~h});
            repeat (8) @(posedge sys_clk);
            trig <= 4'h0;
            #1;
            `CK("held", h, out)
        end
        for (int c = 1; c < 7; c += 2) begin
            ctrl(1'b1, 3'(c), 2'b00, 4'h0);
            @(posedge sys_clk);
            trig <= 4'hf;
            repeat (10) @(posedge sys_clk);
            trig <= 4'h0;
            #1;
            `CK("rsv", h, out)
        end
        // generator has not stepped yet: no noise transfer so far
        lf = `LFSR_SEED;
        for (int k = 0; k < 16; k++) begin
            ctrl(1'b1, 3'h7, 2'b01, 4'(k));
            wr(`OFF_HOLD, 32'h0);
            repeat (6) begin
                wr(`OFF_SWTRIG, 32'h1);
                #1;
                `CK("noise", 12'h000, out & ~12'(amp_of(4'(k))))
                `CK("lfsr", lf & 12'(amp_of(4'(k))), out)
                lf = lfsr_next(lf);
            end
        end
        // second pass runs the full 4095 ramp, the longest part of the run
        for (int w = 2; w < 4; w++) begin
            n = (w == 2) ? 4'($urandom_range(3)) : 4'($urandom_range(15, 11));
            rst();
            ctrl(1'b1, 3'h7, 2'(w), n);
            wr(`OFF_HOLD, 32'h0);
            for (int i = 0; i <= 2 * amp_of(n); i++) begin
                wr(`OFF_SWTRIG, 32'h1);
                #1;
                `CK("tri", 12'((i <= amp_of(n)) ? i : 2 * amp_of(n) - i), out)
            end
        end
        wr(`OFF_CTRL, 32'h0);
        @(posedge sys_clk);
        #1;
        `CK("conv_en", 1'b0, conv_en)
        end_sim();
    end
    initial begin
        #(40 * 60000);
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire

// ===== bench/dac_ctrl_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "dac_ctrl_consts.svh"
module dac_ctrl_properties (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    input wire logic tim6_trigger_out,
    input wire logic tim7_trigger_out,
    input wire logic tim2_trigger_out,
    input wire logic ext_line9,
    input wire logic [11:0] output_data_reg,
    input wire logic converter_enable
);
    // ----
    // control mirror
    // ----
    logic [7:0] ctl;
    logic [11:0] hold_q;
    logic [2:0] tim_d;
    logic en_w;
    logic hw_edge;
    logic sw_fire;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctl <= 8'h00;
        end else if (wr_stb && addr == `OFF_CTRL) begin
            ctl <= wdata[7:0];
        end
    end
    // mirrors clear with the design so a mid-run reset leaves no stale copy
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_q <= 12'h000;
        end else if (wr_stb && addr == `OFF_HOLD) begin
            hold_q <= wdata[11:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tim_d <= 3'h0;
        end else begin
            tim_d <= {tim2_trigger_out, tim7_trigger_out, tim6_trigger_out};
        end
    end
    assign en_w = wdata[0];
    // only plain transfers are timed here: wave offsets are checked by the bench
    assign hw_edge = ctl[2] && ctl[7:6] == 2'b00
        && ((ctl[5:3] == `TSEL_TIM6 && tim6_trigger_out && !tim_d[0])
        || (ctl[5:3] == `TSEL_TIM7 && tim7_trigger_out && !tim_d[1])
        || (ctl[5:3] == `TSEL_TIM2 && tim2_trigger_out && !tim_d[2]));
    assign sw_fire = wr_stb && addr == `OFF_SWTRIG && wdata[0] && ctl[2]
        && ctl[5:3] == `TSEL_SW && ctl[7:6] == 2'b00;
    // ----
    // properties
    // ----
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    sequence hw_land;
        ##1 $stable(output_data_reg) [*2] ##1 output_data_reg == hold_q;
    endsequence
    a_hw_latency: assert property (hw_edge |-> hw_land)
        else $error("hw transfer latency wrong");
    a_sw_latency: assert property (sw_fire |=> output_data_reg == hold_q)
        else $error("sw transfer latency wrong");
    a_untrig_copy: assert property (wr_stb && addr == `OFF_HOLD && !ctl[2]
        |-> ##2 {20'h0, output_data_reg} == ($past(wdata, 2) & 32'hfff))
        else $error("untriggered copy wrong");
    // a trigger caught just before a switch to a reserved code still lands
    a_no_stray_fire: assert property (!wr_stb && !$past(wr_stb) && !$past(wr_stb, 2)
        && !$past(wr_stb, 3) && (!ctl[2] || (ctl[3] && ctl[5:3] != `TSEL_SW))
        |-> $stable(output_data_reg))
        else $error("output changed without trigger");
    a_enable_lag: assert property (wr_stb && addr == `OFF_CTRL
        |-> ##2 converter_enable == $past(en_w, 2))
        else $error("converter enable wrong");
    a_rdata_idle: assert property (!rd_stb |=> rdata == 32'h0)
        else $error("rdata not zero");
    a_read_out: assert property (rd_stb && addr == `OFF_OUT
        |=> rdata == {20'h0, $past(output_data_reg)})
        else $error("output read wrong");
    a_read_zero: assert property (rd_stb && !(addr inside {`OFF_CTRL, `OFF_HOLD, `OFF_OUT,
        `OFF_STATUS}) |=> rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind dac_channel_trigger_wave_control dac_ctrl_properties chk_u (.sys_clk(sys_clk),
    .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .tim6_trigger_out(tim6_trigger_out), .tim7_trigger_out(tim7_trigger_out),
    .tim2_trigger_out(tim2_trigger_out), .ext_line9(ext_line9),
    .output_data_reg(output_data_reg), .converter_enable(converter_enable));
`default_nettype wire

// ===== rtl/dac_channel_trigger_wave_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "dac_ctrl_consts.svh"

module dac_channel_trigger_wave_control
    import dac_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic tim6_trigger_out,
    input wire logic tim7_trigger_out,
    input wire logic tim2_trigger_out,
    input wire logic ext_line9,
    output logic [11:0] output_data_reg,
    output logic converter_enable
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // mask for noise equals amplitude limit for triangle
    function automatic logic [11:0] sel_mask(input logic [3:0] sel);
        logic [11:0] m;
        m = 12'h000;
        if (sel >= `MAMP_MAX) begin
            m = `DATA_MAX;
        end else begin
            m = 12'hfff >> (4'hb - sel);
        end
        return m;
    endfunction

    function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[12] ? `DATA_MAX : s[11:0];
    endfunction

    // ----------------------------------------
    // control register
    // ----------------------------------------
    logic channel_enable;
    logic trigger_enable_ch;
    logic [2:0] trigger_source_sel;
    logic [1:0] wave_gen_sel;
    logic [3:0] mask_amplitude_sel;
    logic [11:0] holding_data_reg;
    logic ctrl_wr;
    logic hold_wr;
    logic sw_wr;

    assign ctrl_wr = wr_stb && (addr == `OFF_CTRL);
    assign hold_wr = wr_stb && (addr == `OFF_HOLD);
    assign sw_wr = wr_stb && (addr == `OFF_SWTRIG) && wdata[0];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            channel_enable <= 1'b0;
            trigger_enable_ch <= 1'b0;
            trigger_source_sel <= 3'h0;
            wave_gen_sel <= 2'h0;
            mask_amplitude_sel <= 4'h0;
        end else if (ctrl_wr) begin
            channel_enable <= wdata[`POS_EN];
            trigger_enable_ch <= wdata[`POS_TEN];
            trigger_source_sel <= wdata[`POS_TSEL +: 3];
            wave_gen_sel <= wdata[`POS_WAVE +: 2];
            mask_amplitude_sel <= wdata[`POS_MAMP +: 4];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            holding_data_reg <= 12'h000;
        end else if (hold_wr) begin
            holding_data_reg <= wdata[11:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            converter_enable <= 1'b0;
        end else begin
            converter_enable <= channel_enable;
        end
    end

    // ----------------------------------------
    // trigger inputs
    // ----------------------------------------
    // timer triggers share our clock: edge detect only
    logic tim6_prev;
    logic tim7_prev;
    logic tim2_prev;
    // external line comes from a pin: three flops, agree filter
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_level;
    logic ext_rise;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tim6_prev <= 1'b0;
            tim7_prev <= 1'b0;
            tim2_prev <= 1'b0;
        end else begin
            tim6_prev <= tim6_trigger_out;
            tim7_prev <= tim7_trigger_out;
            tim2_prev <= tim2_trigger_out;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            ext_level <= 1'b0;
        end else begin
            ext_s1 <= ext_line9;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            if (ext_s2 == ext_s3) begin
                ext_level <= ext_s3;
            end
        end
    end

    assign ext_rise = (ext_s2 == ext_s3) && ext_s3 && !ext_level;

    // ----------------------------------------
    // trigger selection
    // ----------------------------------------
    logic hw_fire;
    logic sw_fire;
    logic [`HW_LATENCY-1:0] hw_pipe;

    // rising edges only, so a long trigger level fires once
    always_comb begin
        hw_fire = 1'b0;
        if (trigger_enable_ch) begin
            case (trigger_source_sel)
                `TSEL_TIM6: hw_fire = tim6_trigger_out && !tim6_prev;
                `TSEL_TIM7: hw_fire = tim7_trigger_out && !tim7_prev;
                `TSEL_TIM2: hw_fire = tim2_trigger_out && !tim2_prev;
                `TSEL_EXT9: hw_fire = ext_rise;
                default: hw_fire = 1'b0;
            endcase
        end
    end

    assign sw_fire = sw_wr && trigger_enable_ch && (trigger_source_sel == `TSEL_SW);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hw_pipe <= '0;
        end else begin
            hw_pipe <= {hw_pipe[`HW_LATENCY-2:0], hw_fire};
        end
    end

    // ----------------------------------------
    // untriggered transfer
    // ----------------------------------------
    logic hold_pend;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_pend <= 1'b0;
        end else begin
            hold_pend <= hold_wr && !trigger_enable_ch;
        end
    end

    // ----------------------------------------
    // wave generation
    // ----------------------------------------
    wave_mode_t wave_mode;
    tri_dir_t tri_dir;
    logic [11:0] lfsr;
    logic [11:0] tri_cnt;
    logic [11:0] wave_val;
    logic [11:0] limit;
    logic trig_load;
    logic load_now;

    always_comb begin
        if (!trigger_enable_ch) begin
            wave_mode = WAVE_OFF;
        end else if (wave_gen_sel[1]) begin
            wave_mode = WAVE_TRI;
        end else if (wave_gen_sel[0]) begin
            wave_mode = WAVE_NOISE;
        end else begin
            wave_mode = WAVE_OFF;
        end
    end

    assign limit = sel_mask(mask_amplitude_sel);
    assign trig_load = trigger_enable_ch && (hw_pipe[`HW_LATENCY-1] || sw_fire);
    assign load_now = trig_load || (hold_pend && !trigger_enable_ch);

    always_comb begin
        case (wave_mode)
            WAVE_NOISE: wave_val = lfsr & limit;
            WAVE_TRI: wave_val = tri_cnt;
            default: wave_val = 12'h000;
        endcase
    end

    // generators step once per accepted trigger
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lfsr <= `LFSR_SEED;
        end else if (trig_load && wave_mode == WAVE_NOISE) begin
            lfsr <= {lfsr[10:0], ^(lfsr & `LFSR_TAPS)};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tri_cnt <= 12'h000;
            tri_dir <= TRI_UP;
        end else if (trig_load && wave_mode == WAVE_TRI) begin
            case (tri_dir)
                TRI_UP: begin
                    if (tri_cnt >= limit) begin
                        tri_dir <= TRI_DOWN;
                        tri_cnt <= tri_cnt - 12'h001;
                    end else begin
                        tri_cnt <= tri_cnt + 12'h001;
                    end
                end
                TRI_DOWN: begin
                    if (tri_cnt == 12'h000) begin
                        tri_dir <= TRI_UP;
                        tri_cnt <= 12'h001;
                    end else begin
                        tri_cnt <= tri_cnt - 12'h001;
                    end
                end
                default: begin
                    tri_dir <= TRI_UP;
                    tri_cnt <= 12'h000;
                end
            endcase
        end
    end

    // ----------------------------------------
    // output data register
    // ----------------------------------------
    // sum saturates rather than wrapping, so no sudden jumps
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            output_data_reg <= 12'h000;
        end else if (load_now) begin
            output_data_reg <= sat_add(holding_data_reg, wave_val);
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata <= 32'h0000_0000;
        end else if (rd_stb) begin
            case (addr)
                `OFF_CTRL: rdata <= {20'h00000, mask_amplitude_sel, wave_gen_sel,
                                     trigger_source_sel, trigger_enable_ch, 1'b0,
                                     channel_enable};
                `OFF_HOLD: rdata <= {20'h00000, holding_data_reg};
                `OFF_OUT: rdata <= {20'h00000, output_data_reg};
                `OFF_STATUS: rdata <= {28'h0000000, tri_dir == TRI_DOWN, hold_pend,
                                       |hw_pipe, converter_enable};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/dac_ctrl_consts.svh
// Summary of operation
// - noise mask unmasks lfsr bits n..0
// - triangle amplitude is 2^(n+1)-1, max 4095
// - wave select: 00 off, 01 noise, 1x triangle
// - wave and source used only with trigger enabled
// - source codes 000,010,100,110,111; others reserved
// - trigger off: output follows hold one cycle later
// - hardware trigger: transfer three cycles later from a timer, six from ext line 9
// - software trigger: transfer within one cycle
// - channel enable bit alone enables converter
`ifndef DAC_CTRL_CONSTS_SVH
`define DAC_CTRL_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_HOLD 8'h04
`define OFF_SWTRIG 8'h08
`define OFF_OUT 8'h0c
`define OFF_STATUS 8'h10

// ----------------------------------------
// control field positions
// ----------------------------------------
`define POS_EN 0
`define POS_TEN 2
`define POS_TSEL 3
`define POS_WAVE 6
`define POS_MAMP 8
`define CTRL_RESET 32'h0000_0000

// ----------------------------------------
// trigger source codes
// ----------------------------------------
`define TSEL_TIM6 3'h0
`define TSEL_TIM7 3'h2
`define TSEL_TIM2 3'h4
`define TSEL_EXT9 3'h6
`define TSEL_SW 3'h7

// ----------------------------------------
// timing and data
// ----------------------------------------
`define HW_LATENCY 2
`define MAMP_MAX 4'hb
`define DATA_MAX 12'hfff
`define LFSR_SEED 12'haaa
`define LFSR_TAPS 12'h829

`endif

// ===== rtl/dac_ctrl_pkg.sv
package dac_ctrl_pkg;
    typedef enum logic [2:0] {
        WAVE_OFF = 3'b001,
        WAVE_NOISE = 3'b010,
        WAVE_TRI = 3'b100
    } wave_mode_t;

    typedef enum logic [1:0] {
        TRI_UP = 2'b01,
        TRI_DOWN = 2'b10
    } tri_dir_t;
endpackage
